// File: design/lid_top.sv
// SPI register bank and low-power input detection control.
`timescale 1ns/1ps
`include "lid_defs.svh"
module lid_top #(
	parameter int GND_CH      = `LID_GND_CH,
	parameter int PRG_CH      = `LID_PRG_CH,
	parameter int TICK_CYCLES = `LID_TICK_PERIOD_US * `LID_CLK_MHZ
) (
	input  wire logic                       clk_i,
	input  wire logic                       arst_n_i,
	input  wire logic                       spi_sclk_i,
	input  wire logic                       spi_cs_n_i,
	input  wire logic                       spi_mosi_i,
	output logic                            spi_miso_o,
	output logic                            spi_miso_oe_o,
	input  wire logic                       fault_status_i,
	input  wire logic                       interrupt_flag_i,
	input  wire logic                       low_power_state_i,
	input  wire logic [PRG_CH-1:0]          programmable_channel_battery_i,
	input  wire logic [GND_CH-1:0]          ground_switch_channel_pin_i,
	output logic [GND_CH-1:0]               ground_cmp_only_on_o,
	output lid_pkg::lid_thr_t [GND_CH-1:0]  ground_thr_o,
	output lid_pkg::lid_thr_t [PRG_CH-1:0]  programmable_thr_o,
	output logic                            wake_o
);
	localparam int RD = `LID_RDATA_BITS;

	if (GND_CH < 1 || GND_CH > RD || PRG_CH < 1 || PRG_CH > RD ||
	    TICK_CYCLES < 2) begin : g_bad
		$error("lid_top parameters out of range");
	end

	// Pin synchronisers; stage 3 only serves edge detection.
	logic [2:0]        sclk_s;
	logic [2:0]        cs_s;
	logic [1:0]        mosi_s;
	logic [GND_CH-1:0] pin_s1;
	logic [GND_CH-1:0] pin_s2;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_s <= 3'h0;
			cs_s   <= 3'h7;
			mosi_s <= 2'h0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			sclk_s <= {sclk_s[1:0], spi_sclk_i};
			cs_s   <= {cs_s[1:0], spi_cs_n_i};
			mosi_s <= {mosi_s[0], spi_mosi_i};
			pin_s1 <= ground_switch_channel_pin_i;
			pin_s2 <= pin_s1;
		end
	end

	logic cs_act;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	assign cs_act   = !cs_s[1];
	assign cs_fall  = cs_s[2] && !cs_s[1];
	assign cs_rise  = !cs_s[2] && cs_s[1];
	assign sck_rise = cs_act && sclk_s[1] && !sclk_s[2];
	assign sck_fall = cs_act && !sclk_s[1] && sclk_s[2];

	// Frame engine and registers.
	logic [31:0]       sh_in;
	logic [31:0]       next_sh_in;
	logic [31:0]       sh_out;
	logic [31:0]       next_sh_out;
	logic [31:0]       reply;
	logic [31:0]       next_reply;
	logic [5:0]        cnt;
	logic [5:0]        next_cnt;
	logic              miso;
	logic              next_miso;
	logic              miso_oe;
	logic [GND_CH-1:0] ground_channel_comparator_only;
	logic [GND_CH-1:0] next_gnd_cmp;
	logic [PRG_CH-1:0] programmable_channel_lpm_threshold;
	logic [PRG_CH-1:0] next_prg_thr;
	logic [GND_CH-1:0] ground_channel_lpm_threshold;
	logic [GND_CH-1:0] next_gnd_thr;

	logic [6:0]        addr;
	logic              rw;
	logic [RD-1:0]     rdata;

	assign addr = sh_in[`LID_ADDR_MSB:`LID_ADDR_LSB];
	assign rw   = sh_in[`LID_RW_BIT];

	always_comb begin
		next_sh_in   = sh_in;
		next_sh_out  = sh_out;
		next_reply   = reply;
		next_cnt     = cnt;
		next_miso    = miso;
		next_gnd_cmp = ground_channel_comparator_only;
		next_prg_thr = programmable_channel_lpm_threshold;
		next_gnd_thr = ground_channel_lpm_threshold;
		rdata        = '0;
		if (cs_fall) begin
			next_cnt    = 6'h00;
			next_sh_out = reply;
			next_miso   = reply[31];
		end else if (sck_rise) begin
			next_sh_in = {sh_in[30:0], mosi_s[1]};
			if (cnt != 6'h3F) begin
				next_cnt = cnt + 6'h01;
			end
		end else if (sck_fall) begin
			next_sh_out = {sh_out[30:0], 1'b0};
			next_miso   = sh_out[30];
		end else if (cs_rise && cnt == `LID_FRAME_BITS) begin
			// Only whole frames act; the reply to this frame goes out
			// during the next one and reflects the value after any write.
			if (rw) begin
				case (addr)
				`LID_ADDR_GND_CMP: begin
					next_gnd_cmp = sh_in[GND_CH-1:0];
				end
				`LID_ADDR_PRG_THR: begin
					next_prg_thr = sh_in[PRG_CH-1:0];
				end
				`LID_ADDR_GND_THR: begin
					next_gnd_thr = sh_in[GND_CH-1:0];
				end
				default: begin
				end
				endcase
			end
			case (addr)
			`LID_ADDR_GND_CMP: begin
				rdata = RD'(next_gnd_cmp);
			end
			`LID_ADDR_PRG_THR: begin
				rdata = RD'(next_prg_thr);
			end
			`LID_ADDR_GND_THR: begin
				rdata = RD'(next_gnd_thr);
			end
			default: begin
				rdata = '0;
			end
			endcase
			next_reply = {addr, rw, fault_status_i, interrupt_flag_i,
			              rdata};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sh_in   <= 32'h00000000;
			sh_out  <= 32'h00000000;
			reply   <= 32'h00000000;
			cnt     <= 6'h00;
			miso    <= 1'b0;
			miso_oe <= 1'b0;
			ground_channel_comparator_only     <= '0;
			programmable_channel_lpm_threshold <= '0;
			ground_channel_lpm_threshold       <= '0;
		end else begin
			sh_in   <= next_sh_in;
			sh_out  <= next_sh_out;
			reply   <= next_reply;
			cnt     <= next_cnt;
			miso    <= next_miso;
			miso_oe <= cs_act;
			ground_channel_comparator_only     <= next_gnd_cmp;
			programmable_channel_lpm_threshold <= next_prg_thr;
			ground_channel_lpm_threshold       <= next_gnd_thr;
		end
	end

	assign spi_miso_o    = miso;
	assign spi_miso_oe_o = miso_oe;

	// Low-power clock: one enable pulse per period, running in low power.
	localparam int TW = $clog2(TICK_CYCLES);
	logic [TW-1:0] tdiv;
	logic [TW-1:0] next_tdiv;
	logic          tick;
	logic          next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_tdiv = tdiv;
		if (!low_power_state_i) begin
			next_tdiv = '0;
		end else if (tdiv == TW'(TICK_CYCLES - 1)) begin
			next_tdiv = '0;
			next_tick = 1'b1;
		end else begin
			next_tdiv = tdiv + TW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tdiv <= '0;
			tick <= 1'b0;
		end else begin
			tdiv <= next_tdiv;
			tick <= next_tick;
		end
	end

	lid_chan_if #(.N(GND_CH)) gnd_if ();
	lid_chan_if #(.N(PRG_CH)) prg_if ();

	assign gnd_if.low_power  = low_power_state_i;
	assign gnd_if.tick       = tick;
	assign gnd_if.comp_only  = ground_channel_comparator_only;
	assign gnd_if.thr_sel    = ground_channel_lpm_threshold;
	assign gnd_if.to_battery = '0;
	assign gnd_if.pin        = pin_s2;

	assign prg_if.low_power  = low_power_state_i;
	assign prg_if.tick       = tick;
	assign prg_if.comp_only  = '0;
	assign prg_if.thr_sel    = programmable_channel_lpm_threshold;
	assign prg_if.to_battery = programmable_channel_battery_i;
	assign prg_if.pin        = '0;

	lid_chan #(.N(GND_CH)) u_gnd (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.ch       (gnd_if.chan)
	);

	lid_chan #(.N(PRG_CH)) u_prg (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.ch       (prg_if.chan)
	);

	assign ground_cmp_only_on_o = gnd_if.cmp_only_on;
	assign ground_thr_o         = gnd_if.thr;
	assign programmable_thr_o   = prg_if.thr;
	assign wake_o               = gnd_if.wake;
endmodule

// File: common/lid_defs.svh
// Constants for the low-power input detection configuration block.
// Operation
// - Comparator-only channel: comparator on, no polling current
// - Comparator-only channel sampled per tick, change wakes
// - Ground-sensing programmable channel, bit clear: delta threshold
// - Ground-sensing programmable channel, bit set: normal threshold
// - Battery-sensing programmable channel always uses 4.0 V
// - Ground channel bit: set normal, clear delta
`ifndef LID_DEFS_SVH
`define LID_DEFS_SVH

`define LID_FRAME_BITS     6'h20
`define LID_ADDR_MSB       31
`define LID_ADDR_LSB       25
`define LID_RW_BIT         24
`define LID_FAULT_BIT      23
`define LID_INT_FLAG_BIT   22
`define LID_RDATA_BITS     22
`define LID_WDATA_BITS     24

`define LID_ADDR_GND_CMP   7'h13
`define LID_ADDR_PRG_THR   7'h14
`define LID_ADDR_GND_THR   7'h15

`define LID_GND_CH         14
`define LID_PRG_CH         8
`define LID_REG_RST        24'h000000

`define LID_CLK_MHZ        20
`define LID_TICK_PERIOD_US 1000

`endif

// File: common/lid_pkg.sv
// Types shared by the low-power input detection configuration block.
package lid_pkg;

	typedef enum logic [1:0] {
		LID_THR_DELTA   = 2'h0,
		LID_THR_NORMAL  = 2'h1,
		LID_THR_BATTERY = 2'h2
	} lid_thr_t;

endpackage

// File: common/lid_chan_if.sv
// Carrier between the register logic and one group of channels.
`timescale 1ns/1ps
interface lid_chan_if #(
	parameter int N = 8
);
	logic                         low_power;
	logic                         tick;
	logic [N-1:0]                 comp_only;
	logic [N-1:0]                 thr_sel;
	logic [N-1:0]                 to_battery;
	logic [N-1:0]                 pin;
	logic [N-1:0]                 cmp_only_on;
	lid_pkg::lid_thr_t [N-1:0]    thr;
	logic                         wake;

	modport ctrl (
		output low_power,
		output tick,
		output comp_only,
		output thr_sel,
		output to_battery,
		output pin,
		input  cmp_only_on,
		input  thr,
		input  wake
	);

	modport chan (
		input  low_power,
		input  tick,
		input  comp_only,
		input  thr_sel,
		input  to_battery,
		input  pin,
		output cmp_only_on,
		output thr,
		output wake
	);
endinterface

// File: design/lid_chan.sv
// Per-group low-power comparator control, sampling and threshold choice.
`timescale 1ns/1ps
module lid_chan #(
	parameter int N = 8
) (
	input  wire logic   clk_i,
	input  wire logic   arst_n_i,
	lid_chan_if.chan    ch
);
	logic [N-1:0]              smp;
	logic [N-1:0]              next_smp;
	logic [N-1:0]              on;
	logic [N-1:0]              next_on;
	lid_pkg::lid_thr_t [N-1:0] thr;
	lid_pkg::lid_thr_t [N-1:0] next_thr;
	logic                      wake;
	logic                      next_wake;

	if (N < 1) begin : g_bad
		$error("lid_chan needs at least one channel");
	end

	always_comb begin
		next_on   = ch.comp_only & {N{ch.low_power}};
		next_smp  = smp;
		next_wake = 1'b0;
		// Outside low power the reference follows the pin, so the first
		// tick compares against the level seen at entry.
		if (!ch.low_power) begin
			next_smp = ch.pin;
		end else if (ch.tick) begin
			next_smp  = ch.pin;
			next_wake = |((ch.pin ^ smp) & ch.comp_only);
		end
		for (int i = 0; i < N; i++) begin
			if (ch.to_battery[i]) begin
				next_thr[i] = lid_pkg::LID_THR_BATTERY;
			end else if (!ch.low_power || ch.thr_sel[i]) begin
				next_thr[i] = lid_pkg::LID_THR_NORMAL;
			end else begin
				next_thr[i] = lid_pkg::LID_THR_DELTA;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			smp  <= '0;
			on   <= '0;
			thr  <= '{default: lid_pkg::LID_THR_NORMAL};
			wake <= 1'b0;
		end else begin
			smp  <= next_smp;
			on   <= next_on;
			thr  <= next_thr;
			wake <= next_wake;
		end
	end

	assign ch.cmp_only_on = on;
	assign ch.thr         = thr;
	assign ch.wake        = wake;
endmodule

// File: test/lid_top_asserts.sv
// Checker on the ports of the detection block.
`timescale 1ns/1ps
module lid_top_asserts #(
	parameter int GND_CH = 14,
	parameter int PRG_CH = 8
) (
	input wire logic                      clk_i,
	input wire logic                      arst_n_i,
	input wire logic                      low_power_state_i,
	input wire logic [PRG_CH-1:0]         programmable_channel_battery_i,
	input wire logic [GND_CH-1:0]         ground_cmp_only_on_o,
	input lid_pkg::lid_thr_t [GND_CH-1:0] ground_thr_o,
	input lid_pkg::lid_thr_t [PRG_CH-1:0] programmable_thr_o,
	input wire logic                      wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_awake;
		!low_power_state_i [*3];
	endsequence
	cmp_off_a:
	assert property (!$past(low_power_state_i) |-> ground_cmp_only_on_o == '0)
		else $error("comparator kept on outside low power");
	wake_pulse_a:
	assert property (wake_o |=> !wake_o) else $error("wake longer than one");
	wake_lpm_a:
	assert property (wake_o |-> $past(low_power_state_i, 2))
		else $error("wake without low power");
	wake_src_a:
	assert property (wake_o |-> $past(ground_cmp_only_on_o) != '0)
		else $error("wake without comparator channel");
	no_wake_a:
	assert property (s_awake |-> !wake_o) else $error("wake while awake");
	bat_thr_a:
	assert property (programmable_channel_battery_i[0] |=>
		programmable_thr_o[0] == lid_pkg::LID_THR_BATTERY)
		else $error("battery channel threshold wrong");
	prg_norm_a:
	assert property (!low_power_state_i && !programmable_channel_battery_i[0]
		|=> programmable_thr_o[0] == lid_pkg::LID_THR_NORMAL)
		else $error("awake programmable threshold wrong");
	gnd_norm_a:
	assert property (!low_power_state_i |=>
		ground_thr_o[GND_CH-1] == lid_pkg::LID_THR_NORMAL)
		else $error("awake ground threshold wrong");
endmodule
bind lid_top lid_top_asserts #(.GND_CH(GND_CH), .PRG_CH(PRG_CH)) u_chk (.*);

// File: test/lid_host.sv
// SPI host model that frames words for the register bank.
`timescale 1ns/1ps
module lid_host (
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Each clock phase lasts four cycles, above the three the bank needs.
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [31:0] r);
		@(negedge clk_i) cs_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			mosi_o = w[31-i];
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			r = {r[30:0], miso_i};
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		repeat (6) @(negedge clk_i);
	endtask
endmodule

// File: test/lpm_input_detect_config_bench.sv
// Self-checking bench for the low-power input detection block.
`timescale 1ns/1ps
module lpm_input_detect_config_bench;
	localparam int LPC = 8;
	logic                     clk, rst_n, sclk, cs_n, mosi, miso, oe;
	logic                     flt, intf, lps, wake, have, seen;
	logic [7:0]               bat;
	logic [13:0]              pin, cmp_on;
	lid_pkg::lid_thr_t [13:0] gthr;
	lid_pkg::lid_thr_t [7:0]  pthr;
	logic [31:0]              seed, exp_rep;
	logic [23:0]              regs [3];
	int                       err_total, num_checks;
	lid_top #(.TICK_CYCLES(LPC)) u_dut (.clk_i(clk), .arst_n_i(rst_n),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
		.spi_miso_o(miso), .spi_miso_oe_o(oe), .fault_status_i(flt),
		.interrupt_flag_i(intf), .low_power_state_i(lps),
		.programmable_channel_battery_i(bat),
		.ground_switch_channel_pin_i(pin), .ground_cmp_only_on_o(cmp_on),
		.ground_thr_o(gthr), .programmable_thr_o(pthr), .wake_o(wake));
	// A released data line shows the inverse of its last level.
	lid_host u_host (.clk_i(clk), .miso_i(oe ? miso : ~miso),
		.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic [6:0] a, input logic w,
		input logic [23:0] d, input int n);
		logic [31:0] r;
		int k;
		seed = lfsr(seed);
		flt = seed[0];
		intf = seed[1];
		u_host.xfer({a, w, d}, n, r);
		if (n == 32) begin
			if (have)
				chk(r, exp_rep);
			have = 1'b1;
			k = a - 7'h13;
			if (w && k >= 0 && k < 3)
				regs[k] = d & (k == 1 ? 24'h0000FF : 24'h003FFF);
			exp_rep = {a, w, flt, intf, 22'h0};
			if (k >= 0 && k < 3)
				exp_rep[21:0] = regs[k][21:0];
		end
	endtask
	task automatic outs();
		repeat (4) @(negedge clk);
		for (int i = 0; i < 14; i++) begin
			chk(cmp_on[i], lps & regs[0][i]);
			chk(gthr[i], lps ? regs[2][i] : 1);
			if (i < 8)
				chk(pthr[i], bat[i] ? 2 : lps ? regs[1][i] : 1);
		end
	endtask
	task automatic wait_wake(input logic e);
		seen = 1'b0;
		repeat (3 * LPC + 6) @(negedge clk) seen |= wake;
		chk(seen, e);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{rst_n, flt, intf, lps, have, bat, pin} = '0;
		seed = 32'hC73C;
		regs = '{default: 24'h0};
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int a = 7'h12; a < 7'h17; a++)
			frame(a, 1'b0, 24'h0, 32);
		$display("reset values done");
		repeat (8) begin
			seed = lfsr(seed);
			frame(7'h13 + seed[3:2], 1'b1, seed[31:8], 32);
		end
		frame(7'h13, 1'b1, 24'hFFFFFF, 31);
		frame(7'h13, 1'b0, 24'h0, 32);
		$display("register access done");
		for (int m = 0; m < 6; m++) begin
			seed = lfsr(seed);
			lps = m[0];
			bat = seed[7:0];
			frame(7'h14, 1'b1, seed[31:8], 32);
			frame(7'h15, 1'b1, seed[23:0], 32);
			outs();
		end
		$display("thresholds done");
		lps = 1'b0;
		frame(7'h13, 1'b1, 24'h000008, 32);
		lps = 1'b1;
		repeat (3 * LPC) @(negedge clk);
		pin[3] = ~pin[3];
		wait_wake(1'b1);
		pin[4] = ~pin[4];
		wait_wake(1'b0);
		$display("wake done");
		conclude();
	end
	initial begin
		#2000000;
		err_total++;
		conclude();
	end
endmodule
